// file: hdl/csp_port.sv
// Clocked serial port with AXI4-Lite registers and one interrupt.
`default_nettype none
module csp_port
    import csp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clock_line_in,
    output logic serial_clock_line_out,
    output logic serial_clock_line_oe,
    input wire logic receive_data_line,
    output logic transmit_data_line,
    output logic irq,
    output logic [1:0] irq_priority
);
    // Register state
    logic [7:0] tx_data, rx_data, divisor;
    logic tx_full, rx_full, send_pend, recv_pend;
    logic [1:0] mode, prio, istat, imask;
    // Bus state
    logic [4:0] aw_addr;
    logic [31:0] w_data, rd_value;
    logic [3:0] w_strb;
    logic aw_got, w_got, wr_fire, rd_fire, wr_mapped, rd_mapped;
    logic wr_data, wr_ctrl, rd_data_clr, rd_istat_clr;
    // Shift engine
    csp_state_e state;
    logic [7:0] tx_shift, rx_shift;
    logic [3:0] rises;
    logic do_rx, do_tx, gen_clk, tick, ext_rise, ext_fall, rx_level;
    logic clk_rise, clk_fall, start, load_tx, burst_done;
    logic [31:0] status_word;

    // External serial clock crosses into aclk before any shifting
    csp_sync u_clk_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(serial_clock_line_in),
        .level(),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    // Receive line shares the same two-flop crossing
    csp_sync u_rx_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(receive_data_line),
        .level(rx_level),
        .rise(),
        .fall()
    );

    // Half-period ticks for the internally made clock
    csp_divider u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(state == CSP_BURST && mode == MODE_INT),
        .half_period(divisor),
        .tick(tick)
    );

    // Edge events: own divider in internal mode, strobes in external mode, none otherwise
    always_comb begin
        clk_rise = 1'b0;
        clk_fall = 1'b0;
        if (mode == MODE_INT) begin
            clk_rise = tick & ~gen_clk;
            clk_fall = tick & gen_clk;
        end else if (mode == MODE_EXT) begin
            clk_rise = ext_rise;
            clk_fall = ext_fall;
        end
    end

    // Burst starts when a receive code, or a send code with a byte loaded, is pending, the mode is not off and the shifter is idle
    assign load_tx = send_pend & tx_full;
    assign start = (state == CSP_IDLE) && (mode != MODE_OFF)
                   && (load_tx || recv_pend);
    assign burst_done = (state == CSP_BURST) && clk_rise && (rises == BURST_BITS - 4'h1);

    // Bus-side decode of writes and reads
    assign wr_fire = aw_got & w_got & ~s_axi_bvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign wr_data = wr_fire && aw_addr == OFS_DATA && w_strb[0];
    assign wr_ctrl = wr_fire && aw_addr == OFS_CONTROL && w_strb[0];
    assign rd_data_clr = rd_fire && s_axi_araddr == OFS_DATA;
    assign rd_istat_clr = rd_fire && s_axi_araddr == OFS_ISTAT;

    always_comb begin
        case (aw_addr)
            OFS_DATA, OFS_STATUS, OFS_CONTROL, OFS_DIVISOR, OFS_ISTAT, OFS_IMASK: begin
                wr_mapped = 1'b1;
            end
            default: begin
                wr_mapped = 1'b0;
            end
        endcase
    end

    // Status visible at any time for the dispatcher
    assign status_word = {24'h000000, rx_full, 3'h0, tx_full, state == CSP_BURST,
                          send_pend, recv_pend};

    // Read multiplexer
    always_comb begin
        rd_value = 32'h00000000;
        rd_mapped = 1'b1;
        case (s_axi_araddr)
            OFS_DATA: begin
                rd_value = {24'h000000, rx_data};
            end
            OFS_STATUS: begin
                rd_value = status_word;
            end
            OFS_CONTROL: begin
                rd_value = {24'h000000, 4'h0, mode, prio};
            end
            OFS_DIVISOR: begin
                rd_value = {24'h000000, divisor};
            end
            OFS_ISTAT: begin
                rd_value = {30'h00000000, istat};
            end
            OFS_IMASK: begin
                rd_value = {30'h00000000, imask};
            end
            default: begin
                rd_mapped = 1'b0;
            end
        endcase
    end

    // Write channels taken in either order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 5'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_addr <= {s_axi_awaddr[4:2], 2'h0};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel, one outstanding read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= MODE_OFF;
            prio <= PRIO_RESET;
            divisor <= DIV_RESET;
            imask <= 2'h0;
        end else if (wr_fire && w_strb[0]) begin
            if (aw_addr == OFS_CONTROL) begin
                mode <= w_data[CT_MODE_HI:CT_MODE_LO];
                prio <= w_data[CT_PRIO_HI:CT_PRIO_LO];
            end
            if (aw_addr == OFS_DIVISOR) begin
                divisor <= w_data[7:0];
            end
            if (aw_addr == OFS_IMASK) begin
                imask <= w_data[1:0];
            end
        end
    end

    // Send and receive codes, one per byte; taken at burst start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            send_pend <= 1'b0;
            recv_pend <= 1'b0;
        end else begin
            if (start) begin
                send_pend <= 1'b0;
                recv_pend <= 1'b0;
            end
            if (wr_ctrl && w_data[CT_CMD_HI:CT_CMD_LO] == CMD_SEND) begin
                send_pend <= 1'b1;
            end
            if (wr_ctrl && w_data[CT_CMD_HI:CT_CMD_LO] == CMD_RECV) begin
                recv_pend <= 1'b1;
            end
        end
    end

    // Transmit data register; a new byte may wait while one shifts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_data <= 8'h00;
            tx_full <= 1'b0;
        end else if (wr_data) begin
            tx_data <= w_data[7:0];
            tx_full <= 1'b1;
        end else if (start && load_tx) begin
            tx_full <= 1'b0;
        end
    end

    // Shift engine: eight clocks per burst
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= CSP_IDLE;
            tx_shift <= 8'hFF;
            rx_shift <= 8'h00;
            rises <= 4'h0;
            do_rx <= 1'b0;
            do_tx <= 1'b0;
            transmit_data_line <= 1'b1;
        end else begin
            case (state)
                CSP_IDLE: begin
                    if (start) begin
                        state <= CSP_BURST;
                        tx_shift <= load_tx ? tx_data : 8'hFF;
                        do_tx <= load_tx;
                        do_rx <= recv_pend;
                        rises <= 4'h0;
                    end
                end
                CSP_BURST: begin
                    if (mode == MODE_OFF) begin
                        state <= CSP_IDLE;
                    end else begin
                        if (clk_fall) begin
                            transmit_data_line <= tx_shift[0];
                            tx_shift <= {1'b1, tx_shift[7:1]};
                        end
                        if (clk_rise) begin
                            rx_shift <= {rx_level, rx_shift[7:1]};
                            rises <= rises + 4'h1;
                        end
                        if (burst_done) begin
                            state <= CSP_IDLE;
                        end
                    end
                end
                default: begin
                    state <= CSP_IDLE;
                end
            endcase
        end
    end

    // Internal clock idles high, toggles on each divider tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gen_clk <= 1'b1;
        end else if (state != CSP_BURST || mode != MODE_INT) begin
            gen_clk <= 1'b1;
        end else if (tick) begin
            gen_clk <= ~gen_clk;
        end
    end

    // Pin drivers; the external party drives the line in external mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_clock_line_out <= 1'b1;
            serial_clock_line_oe <= 1'b0;
        end else begin
            serial_clock_line_out <= gen_clk;
            serial_clock_line_oe <= (mode == MODE_INT);
        end
    end

    // Receive data register; full flag set wins over a read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_data <= 8'h00;
            rx_full <= 1'b0;
        end else if (burst_done && do_rx) begin
            rx_data <= {rx_level, rx_shift[7:1]};
            rx_full <= 1'b1;
        end else if (rd_data_clr) begin
            rx_full <= 1'b0;
        end
    end

    // Separate sticky request flops, so simultaneous events both survive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat <= 2'h0;
        end else begin
            if (burst_done && do_rx) begin
                istat[IRQ_RX] <= 1'b1;
            end else if (rd_data_clr || rd_istat_clr) begin
                istat[IRQ_RX] <= 1'b0;
            end
            if (start && load_tx) begin
                istat[IRQ_TX] <= 1'b1;
            end else if (rd_istat_clr || wr_data) begin
                istat[IRQ_TX] <= 1'b0;
            end
        end
    end

    // One shared request line with its priority level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
            irq_priority <= PRIO_RESET;
        end else begin
            irq <= |(istat & imask);
            irq_priority <= prio;
        end
    end
endmodule
`default_nettype wire

// file: hdl/csp_pkg.sv
// Constants shared by the clocked serial port and its helpers.
`default_nettype none
package csp_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_DATA = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_CONTROL = 5'h08;
    localparam logic [4:0] OFS_DIVISOR = 5'h0C;
    localparam logic [4:0] OFS_ISTAT = 5'h10;
    localparam logic [4:0] OFS_IMASK = 5'h14;
    // Status field positions
    localparam int ST_RX_FULL = 7;
    localparam int ST_TX_FULL = 3;
    localparam int ST_BUSY = 2;
    localparam int ST_SEND_PEND = 1;
    localparam int ST_RECV_PEND = 0;
    // Control fields
    localparam int CT_CMD_HI = 7;
    localparam int CT_CMD_LO = 6;
    localparam int CT_MODE_HI = 3;
    localparam int CT_MODE_LO = 2;
    localparam int CT_PRIO_HI = 1;
    localparam int CT_PRIO_LO = 0;
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_RECV = 2'h1;
    localparam logic [1:0] CMD_SEND = 2'h2;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_INT = 2'h2;
    localparam logic [1:0] MODE_EXT = 2'h3;
    localparam logic [1:0] PRIO_RESET = 2'h1;
    // Interrupt status bit positions
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    // Half-period of the internal clock in perclk cycles
    localparam logic [7:0] DIV_MIN = 8'h02;
    localparam logic [7:0] DIV_RESET = 8'h04;
    localparam logic [3:0] BURST_BITS = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [0:0] {CSP_IDLE, CSP_BURST} csp_state_e;
endpackage
`default_nettype wire

// file: hdl/csp_sync.sv
// Two-flop synchroniser with rise and fall strobes.
`default_nettype none
module csp_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic stage1;
    logic stage2;
    logic prev;

    // First stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    // Edge strobes rise one to two cycles after the pin edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev <= 1'b1;
        end else begin
            prev <= stage2;
        end
    end

    assign level = stage2;
    assign rise = stage2 & ~prev;
    assign fall = ~stage2 & prev;
endmodule
`default_nettype wire

// file: hdl/csp_divider.sv
// Enable-pulse divider for the internal serial clock.
`default_nettype none
module csp_divider
    import csp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [7:0] half_period,
    output logic tick
);
    logic [7:0] count;
    logic [7:0] limit;

    // Clamp keeps the generated clock at or below perclk/4
    assign limit = (half_period < DIV_MIN) ? DIV_MIN : half_period;

    // Counter restarts whenever the burst is not running
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            count <= 8'h01;
            tick <= 1'b0;
        end else if (count >= limit) begin
            count <= 8'h01;
            tick <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: test/csp_port_chk.sv
// Concurrent checks on the clocked serial port's pins and register bus.
`default_nettype none
module csp_port_chk
    import csp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clock_line_in,
    input wire logic serial_clock_line_out,
    input wire logic serial_clock_line_oe,
    input wire logic transmit_data_line,
    input wire logic irq,
    input wire logic [1:0] irq_priority
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic hs;
    logic wtake;
    // Any completed bus transfer, the only thing that may clear a request
    assign hs = (s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready);
    assign wtake = s_axi_wvalid && s_axi_wready;

    a_half_period_min: assert property (
        serial_clock_line_oe && $changed(serial_clock_line_out) |=> $stable(serial_clock_line_out))
        else $error("internal serial clock level shorter than two cycles");
    a_sync_no_shortcut: assert property (
        !serial_clock_line_oe && $changed(transmit_data_line)
        |-> !$fell(serial_clock_line_in) && ($past(serial_clock_line_in, 1)
        || !$past(serial_clock_line_in, 2)))
        else $error("transmit line moved before the clock edge was synchronised");
    a_irq_drop_cause: assert property (
        $fell(irq) |-> $past(hs, 1) || $past(hs, 2) || $past(hs, 3))
        else $error("interrupt dropped without a register access");
    a_prio_reset: assert property (
        $rose(aresetn) |-> irq_priority == PRIO_RESET)
        else $error("priority level wrong after reset");
    a_prio_by_write: assert property (
        $changed(irq_priority) |-> $past(wtake, 2) || $past(wtake, 3))
        else $error("priority level changed without a write");
    a_oe_by_write: assert property (
        $changed(serial_clock_line_oe) |-> $past(wtake, 2) || $past(wtake, 3))
        else $error("clock source changed without a write");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_write_readies: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_unmapped_resp: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 5'h14 |=> s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
endmodule

bind csp_port csp_port_chk u_csp_port_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .serial_clock_line_in(serial_clock_line_in), .serial_clock_line_out(serial_clock_line_out),
    .serial_clock_line_oe(serial_clock_line_oe), .transmit_data_line(transmit_data_line),
    .irq(irq), .irq_priority(irq_priority));
`default_nettype wire

// file: test/csp_partner.sv
// Behavioural external synchronous serial device.
`default_nettype none
module csp_partner (
    input wire logic clk_line,
    input wire logic tx_line,
    input wire logic [7:0] send_byte,
    output logic rx_line,
    output logic [7:0] got_byte,
    output logic clk_drive,
    output logic clk_en
);
    timeunit 1ns;
    timeprecision 100ps;
    int falls;
    int rises;
    // Counters cleared after the time-zero settling of the clock wire
    initial begin
        clk_drive = 1'b1;
        clk_en = 1'b0;
        rx_line = 1'b1;
        #1 falls = 0;
        rises = 0;
        got_byte = 8'h00;
    end
    // Next bit, LSB first, leaves on each falling edge
    always @(negedge clk_line) begin
        rx_line <= send_byte[falls[2:0]];
        falls <= falls + 1;
    end
    // Sample on rising edge; line driven to the inverse of bit 7 shortly after the eighth
    always @(posedge clk_line) begin
        got_byte <= {tx_line, got_byte[7:1]};
        if (rises == 7) begin
            rises <= 0;
            falls <= 0;
            rx_line <= #50 ~send_byte[7];
        end else begin
            rises <= rises + 1;
        end
    end
    // Eight clocks at 8 MHz, below a sixth of the 100 MHz clock; idles high
    task automatic burst();
        #1; // Keeps pin edges off the sampling edge of aclk
        clk_en = 1'b1;
        repeat (8) begin
            clk_drive = 1'b0;
            #62.5;
            clk_drive = 1'b1;
            #62.5;
        end
        clk_en = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: test/clocked_serial_port_timing_bench.sv
// Self-checking bench for the clocked serial port.
`default_nettype none
module clocked_serial_port_timing_bench
    import csp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, clk_out, clk_oe, tx_line, irq;
    logic [1:0] bresp, rresp, irq_priority;
    logic [31:0] rdata;
    logic p_clk, p_en, rx_line;
    logic [7:0] p_got;
    logic [7:0] p_send = 8'h00;
    wire logic clk_wire;
    int fail_count = 0;
    int samples_checked = 0;
    // Clock wire: device, else partner, else pull-up
    assign clk_wire = (clk_oe === 1'b1) ? clk_out : ((p_en === 1'b1) ? p_clk : 1'b1);
    always #5 aclk = ~aclk;

    csp_port u_csp_port (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_clock_line_in(clk_wire), .serial_clock_line_out(clk_out),
        .serial_clock_line_oe(clk_oe), .receive_data_line(rx_line),
        .transmit_data_line(tx_line), .irq(irq), .irq_priority(irq_priority));
    csp_partner u_csp_partner (.clk_line(clk_wire), .tx_line(tx_line), .send_byte(p_send),
        .rx_line(rx_line), .got_byte(p_got), .clk_drive(p_clk), .clk_en(p_en));

    function automatic logic [7:0] ctl(input logic [1:0] c, input logic [1:0] m,
        input logic [1:0] p);
        return {c, 2'b00, m, p};
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic axi_write(input logic [4:0] a, input logic [7:0] d, input logic [3:0] st);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        check("write response", {30'h0, RESP_OKAY}, {30'h0, bresp});
    endtask
    task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(what, exp, d & m);
    endtask
    // Poll busy under a bound rather than trusting a cycle count
    task automatic wait_idle();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        do begin
            axi_read(OFS_STATUS, d, r);
            n++;
        end while (d[ST_BUSY] !== 1'b0 && n < 60);
        if (n >= 60) fail_count++;
    endtask
    task automatic test_reset();
        logic [31:0] d;
        logic [1:0] r;
        rd_chk("status", OFS_STATUS, 32'hFFFFFFFF, 32'h0);
        rd_chk("divisor", OFS_DIVISOR, 32'hFFFFFFFF, {24'h0, DIV_RESET});
        rd_chk("mask", OFS_IMASK, 32'hFFFFFFFF, 32'h0);
        axi_read(5'h18, d, r);
        check("unmapped response", {30'h0, RESP_SLVERR}, {30'h0, r});
        check("priority", {30'h0, PRIO_RESET}, {30'h0, irq_priority});
        check("irq", 32'h0, {31'h0, irq});
        axi_write(OFS_CONTROL, ctl(CMD_NONE, MODE_OFF, 2'h3), 4'h0);
        repeat (2) @(posedge aclk);
        check("priority unstrobed", {30'h0, PRIO_RESET}, {30'h0, irq_priority});
        axi_write(OFS_CONTROL, ctl(CMD_NONE, MODE_OFF, 2'h3), 4'hF);
        repeat (2) @(posedge aclk);
        check("priority raised", 32'h3, {30'h0, irq_priority});
        axi_write(OFS_CONTROL, ctl(CMD_NONE, MODE_OFF, PRIO_RESET), 4'hF);
        $display("test reset done");
    endtask
    task automatic test_int_send();
        axi_write(OFS_IMASK, 8'h00, 4'hF);
        axi_write(OFS_DATA, 8'hA5, 4'hF);
        axi_write(OFS_CONTROL, ctl(CMD_SEND, MODE_INT, PRIO_RESET), 4'hF);
        repeat (2) @(posedge aclk);
        check("clock drive", 32'h1, {31'h0, clk_oe});
        wait_idle();
        check("sent byte", 32'hA5, {24'h0, p_got});
        p_send <= 8'hC3;
        axi_write(OFS_CONTROL, ctl(CMD_RECV, MODE_INT, PRIO_RESET), 4'hF);
        wait_idle();
        rd_chk("int rx byte", OFS_DATA, 32'hFFFFFFFF, 32'hC3);
        check("masked irq", 32'h0, {31'h0, irq});
        axi_write(OFS_IMASK, 8'h03, 4'hF);
        repeat (3) @(posedge aclk);
        check("irq", 32'h1, {31'h0, irq});
        rd_chk("events", OFS_ISTAT, 32'hFF, 32'h2);
        repeat (3) @(posedge aclk);
        check("irq cleared", 32'h0, {31'h0, irq});
        $display("test internal send done");
    endtask
    task automatic test_ext_dual();
        axi_write(OFS_DATA, 8'h5A, 4'hF);
        axi_write(OFS_CONTROL, ctl(CMD_SEND, MODE_EXT, PRIO_RESET), 4'hF);
        repeat (2) @(posedge aclk);
        check("clock released", 32'h0, {31'h0, clk_oe});
        p_send <= 8'h3C;
        u_csp_partner.burst();
        wait_idle();
        check("ext sent byte", 32'h5A, {24'h0, p_got});
        axi_write(OFS_CONTROL, ctl(CMD_RECV, MODE_EXT, PRIO_RESET), 4'hF);
        u_csp_partner.burst();
        wait_idle();
        check("irq", 32'h1, {31'h0, irq});
        rd_chk("rx full", OFS_STATUS, 32'h80, 32'h80);
        rd_chk("rx byte", OFS_DATA, 32'hFFFFFFFF, 32'h3C);
        rd_chk("rx full cleared", OFS_STATUS, 32'h80, 32'h0);
        rd_chk("events kept", OFS_ISTAT, 32'hFF, 32'h2);
        $display("test external duplex done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog at 20000 cycles, far beyond the several hundred cycles the tests need
    initial begin
        #200000;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset();
        test_int_send();
        test_ext_dual();
        conclude();
    end
endmodule
`default_nettype wire
